// [core/pwm_pkg.sv]
// Constants shared by the inverter PWM timer core and its dead-band stage.
// Assumes a single system clock and a synchronous active-high reset.

package pwm_pkg;

	// ==========================================================
	// Widths and bus map
	localparam int CNT_W = 10;
	localparam int DT_W = 8;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int NUM_CMP = 6;
	localparam int PER_IDX = 3;
	localparam logic [4:0] OFS_CMP = 5'h00;
	localparam logic [4:0] OFS_SHD = 5'h06;
	localparam logic [4:0] OFS_SHL = 5'h0C;
	localparam logic [4:0] OFS_DT = 5'h12;
	localparam logic [4:0] OFS_CTL = 5'h13;
	localparam logic [4:0] OFS_MODE = 5'h14;

	// ==========================================================
	// Field positions
	localparam int CTL_RUN = 7;
	localparam int CTL_CLK_LO = 3;
	localparam int CTL_DIV_LO = 0;
	localparam int MODE_OK = 4;
	localparam int MODE_ALV = 3;
	localparam logic [7:0] CTL_MASK = 8'hBF;

	// ==========================================================
	// Values after reset
	localparam logic [9:0] CMP_RST = 10'h000;
	localparam logic [9:0] PER_RST = 10'h0FF;
	localparam logic [7:0] DT_RST = 8'hFF;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [2:0] RTM_RST = 3'h7;
	localparam logic [7:0] DTC_IDLE = 8'hFF;
	localparam logic [9:0] CNT_ZERO = 10'h000;

	// ==========================================================
	// Timing: the shortest dead band is one system clock period.
	localparam int CLK_PERIOD_NS = 50;
	localparam int DEAD_MIN_NS = 50;
	localparam int DEAD_MIN_CYC = (DEAD_MIN_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	typedef enum logic [1:0]
	{
		DIR_UP = 2'b01,
		DIR_DOWN = 2'b10
	} dir_e;

endpackage

// [core/dead_band.sv]
// One phase: output flip-flop plus 8-bit dead-time down-counter.
// Assumes match is a single-cycle pulse taken from the triangle counter.
`timescale 1ns/1ps
`default_nettype none

module dead_band
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic match,
	input wire logic [7:0] reload,
	output logic pos,
	output logic neg
);

	logic [7:0] dcnt;
	logic busy;
	logic ph;
	logic [7:0] next_dcnt;
	logic next_busy;
	logic next_ph;

	// ==========================================================
	// Dead-time counter
	always_comb
	begin
		next_dcnt = dcnt;
		next_busy = busy;
		next_ph = ph;
		if (clear)
		begin
			next_dcnt = pwm_pkg::DTC_IDLE;
			next_busy = 1'b0;
			next_ph = 1'b0;
		end
		else if (match)
		begin
			next_ph = ~ph;
			next_dcnt = reload;
			next_busy = 1'b1;
		end
		else if (busy)
		begin
			// Passing 00 wraps to FF, which is where the counter rests.
			next_dcnt = dcnt - 8'h01;
			if (dcnt == 8'h00)
				next_busy = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dcnt <= pwm_pkg::DTC_IDLE;
			busy <= 1'b0;
			ph <= 1'b0;
			pos <= 1'b0;
			neg <= 1'b0;
		end
		else
		begin
			dcnt <= next_dcnt;
			busy <= next_busy;
			ph <= next_ph;
			pos <= ~next_busy & next_ph;
			neg <= ~next_busy & ~next_ph;
		end
	end

	// ==========================================================
	// Checks
	a_dead_min: assert property (@(posedge clk) disable iff (rst)
		match && !clear |=> !pos && !neg)
		else $error("dead band shorter than one clock");

endmodule
`default_nettype wire

// [core/inverter_pwm_timer_core.sv]
// Three-phase inverter PWM timer: triangle counter, compares, dead bands.
// Assumes a register master that holds each strobe for one cycle.
// Behaviour
// - 10-bit triangle counter rises from zero to period.
// - Reaching zero downward gives underflow and valley.
// - Direction turns on the tick after match.
// - Valley interrupt every underflow unless divided.
// - Triangle counter is never software visible.
// - Count clock prescaler divides by 1 to 32.
// - Reset or run clear zeroes the counter.
// - Phase compare match toggles the phase flip-flop.
// - Auxiliary compare match raises its own interrupt.
// - Shadows copy into compares at valley interrupt.
// - Direct compare writes only while stopped.
// - Reset or run clear zeroes five compares.
// - Period compare resets to 0FFH.
// - Shadows readable and writable at any time.
// - Shadows reset to zero, period shadow 0FFH.
// - Shadows take word and low-byte access.
// - One dead-time reload shared by three counters.
// - Dead-time reload writes only while stopped.
// - Dead-time reload resets to FFH.
// - Dead band lasts at least one clock.
// - Six non-overlapping outputs, level select, stop input.
// - Dead counter reloads on match, holds at FFH.
// - Divider field 000..111 means one per 1..8.
// - Run clear stops all counters, floats outputs.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module inverter_pwm_timer_core
#(
	parameter int NUM_PH = 3
)
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [4:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic EXT_STOP,
	output logic [5:0] PWM_OUT,
	output logic [5:0] PWM_OE_N,
	output logic UNDERFLOW,
	output logic VALLEY_IRQ,
	output logic AUX_IRQ_A,
	output logic AUX_IRQ_B
);

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);

	logic [9:0] cmp [pwm_pkg::NUM_CMP];
	logic [9:0] shd [pwm_pkg::NUM_CMP];
	logic [9:0] next_cmp [pwm_pkg::NUM_CMP];
	logic [9:0] next_shd [pwm_pkg::NUM_CMP];
	logic [7:0] dt;
	logic [7:0] next_dt;
	logic [7:0] ctl;
	logic [7:0] next_ctl;
	logic alv;
	logic next_alv;
	logic out_ok;
	logic next_out_ok;
	logic [15:0] next_rdata;
	logic run;
	logic [2:0] clk_sel;
	logic [2:0] div;
	logic stop_write;
	logic start_write;
	logic [4:0] presc;
	logic [4:0] next_presc;
	logic [4:0] presc_mask;
	logic tick;
	logic tick_q;
	logic start_q;
	logic fresh;
	logic [9:0] cnt;
	logic [9:0] next_cnt;
	pwm_pkg::dir_e dir;
	pwm_pkg::dir_e next_dir;
	logic [2:0] rtm;
	logic [2:0] next_rtm;
	logic [2:0] rtm_inc;
	logic uf;
	logic valley;
	logic [pwm_pkg::NUM_CMP-1:0] match;
	logic [5:0] act;

	assign run = ctl[pwm_pkg::CTL_RUN];
	assign clk_sel = ctl[pwm_pkg::CTL_CLK_LO +: 3];
	assign div = ctl[pwm_pkg::CTL_DIV_LO +: 3];
	assign stop_write = WR && ADDR == pwm_pkg::OFS_CTL
		&& !WDATA[pwm_pkg::CTL_RUN];
	assign start_write = WR && ADDR == pwm_pkg::OFS_CTL
		&& WDATA[pwm_pkg::CTL_RUN] && !run;

	// ==========================================================
	// Register file
	always_comb
	begin
		for (int i = 0; i < pwm_pkg::NUM_CMP; i++)
		begin
			next_cmp[i] = cmp[i];
			next_shd[i] = shd[i];
			if (WR && ADDR == pwm_pkg::OFS_SHD + 5'(i))
				next_shd[i] = WDATA[9:0];
			if (WR && ADDR == pwm_pkg::OFS_SHL + 5'(i))
				next_shd[i][7:0] = WDATA[7:0];
			if (WR && ADDR == pwm_pkg::OFS_CMP + 5'(i) && !run)
				next_cmp[i] = WDATA[9:0];
			if (valley)
				next_cmp[i] = shd[i];
			if (stop_write && i != pwm_pkg::PER_IDX)
				next_cmp[i] = pwm_pkg::CMP_RST;
		end
		next_dt = dt;
		if (WR && ADDR == pwm_pkg::OFS_DT && !run)
			next_dt = WDATA[7:0];
		next_ctl = ctl;
		if (WR && ADDR == pwm_pkg::OFS_CTL)
			next_ctl = WDATA[7:0] & pwm_pkg::CTL_MASK;
		next_alv = alv;
		if (WR && ADDR == pwm_pkg::OFS_MODE)
			next_alv = WDATA[pwm_pkg::MODE_ALV];
		// A stop seen in the same cycle as a start still wins.
		next_out_ok = out_ok;
		if (start_write)
			next_out_ok = 1'b1;
		if (!next_ctl[pwm_pkg::CTL_RUN] || EXT_STOP)
			next_out_ok = 1'b0;
	end

	// The triangle counter has no address, so it cannot be read.
	always_comb
	begin
		next_rdata = 16'h0000;
		if (RD)
		begin
			for (int i = 0; i < pwm_pkg::NUM_CMP; i++)
			begin
				if (ADDR == pwm_pkg::OFS_CMP + 5'(i))
					next_rdata = {6'h00, cmp[i]};
				if (ADDR == pwm_pkg::OFS_SHD + 5'(i))
					next_rdata = {6'h00, shd[i]};
				if (ADDR == pwm_pkg::OFS_SHL + 5'(i))
					next_rdata = {8'h00, shd[i][7:0]};
			end
			if (ADDR == pwm_pkg::OFS_DT)
				next_rdata = {8'h00, dt};
			if (ADDR == pwm_pkg::OFS_CTL)
				next_rdata = {8'h00, ctl};
			if (ADDR == pwm_pkg::OFS_MODE)
				next_rdata = {11'h000, out_ok, alv, 3'h0};
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			for (int i = 0; i < pwm_pkg::NUM_CMP; i++)
			begin
				cmp[i] <= pwm_pkg::CMP_RST;
				shd[i] <= pwm_pkg::CMP_RST;
			end
			cmp[pwm_pkg::PER_IDX] <= pwm_pkg::PER_RST;
			shd[pwm_pkg::PER_IDX] <= pwm_pkg::PER_RST;
			dt <= pwm_pkg::DT_RST;
			ctl <= pwm_pkg::CTL_RST;
			alv <= 1'b0;
			out_ok <= 1'b0;
			RDATA <= 16'h0000;
		end
		else
		begin
			cmp <= next_cmp;
			shd <= next_shd;
			dt <= next_dt;
			ctl <= next_ctl;
			alv <= next_alv;
			out_ok <= next_out_ok;
			RDATA <= next_rdata;
		end
	end

	// ==========================================================
	// Prescaler and triangle counter
	// Codes 6 and 7 are prohibited; they fall back to divide by 32.
	assign presc_mask = ~(5'h1F << clk_sel);
	assign tick = run && (presc & presc_mask) == presc_mask;
	assign rtm_inc = rtm + 3'h1;

	always_comb
	begin
		next_presc = presc + 5'h01;
		next_cnt = cnt;
		next_dir = dir;
		next_rtm = rtm;
		uf = 1'b0;
		valley = 1'b0;
		if (!run)
		begin
			next_presc = 5'h00;
			next_cnt = pwm_pkg::CNT_ZERO;
			next_dir = pwm_pkg::DIR_UP;
			next_rtm = pwm_pkg::RTM_RST;
		end
		else if (tick)
		begin
			unique case (dir)
				pwm_pkg::DIR_UP:
				begin
					if (cnt == cmp[pwm_pkg::PER_IDX])
					begin
						next_dir = pwm_pkg::DIR_DOWN;
						next_cnt = cnt - 10'h001;
					end
					else
						next_cnt = cnt + 10'h001;
				end
				pwm_pkg::DIR_DOWN:
				begin
					if (cnt == pwm_pkg::CNT_ZERO)
					begin
						next_dir = pwm_pkg::DIR_UP;
						next_cnt = cnt + 10'h001;
					end
					else
					begin
						next_cnt = cnt - 10'h001;
						uf = cnt == 10'h001;
					end
				end
				default:
				begin
					next_dir = pwm_pkg::DIR_UP;
					next_cnt = pwm_pkg::CNT_ZERO;
				end
			endcase
			if (uf)
			begin
				next_rtm = rtm_inc;
				if (rtm_inc == div)
				begin
					valley = 1'b1;
					next_rtm = pwm_pkg::RTM_RST;
				end
			end
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			presc <= 5'h00;
			cnt <= pwm_pkg::CNT_ZERO;
			dir <= pwm_pkg::DIR_UP;
			rtm <= pwm_pkg::RTM_RST;
			tick_q <= 1'b0;
			start_q <= 1'b0;
			UNDERFLOW <= 1'b0;
			VALLEY_IRQ <= 1'b0;
		end
		else
		begin
			presc <= next_presc;
			cnt <= next_cnt;
			dir <= next_dir;
			rtm <= next_rtm;
			tick_q <= tick;
			start_q <= start_write;
			UNDERFLOW <= uf;
			VALLEY_IRQ <= valley;
		end
	end

	// ==========================================================
	// Compare match and outputs
	// A match counts once per count value, not once per system clock.
	assign fresh = run && (tick_q || start_q);
	always_comb
	begin
		for (int i = 0; i < pwm_pkg::NUM_CMP; i++)
			match[i] = fresh && cnt == cmp[i];
	end

	for (genvar g = 0; g < NUM_PH; g++)
	begin : g_phase
		dead_band u_band
		(
			.clk(MCLK),
			.rst(RST),
			.clear(!run),
			.match(match[g]),
			.reload(dt),
			.pos(act[2*g]),
			.neg(act[2*g+1])
		);
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			PWM_OUT <= 6'h00;
			AUX_IRQ_A <= 1'b0;
			AUX_IRQ_B <= 1'b0;
		end
		else
		begin
			PWM_OUT <= alv ? act : ~act;
			AUX_IRQ_A <= match[4];
			AUX_IRQ_B <= match[5];
		end
	end

	// Pins float whenever the timer is stopped or the stop input fired.
	assign PWM_OE_N = {6{~out_ok}};

	// ==========================================================
	// Checks
	a_period_turn: assert property (
		tick && dir == pwm_pkg::DIR_UP && cnt == cmp[pwm_pkg::PER_IDX]
		&& ctl == $past(ctl) && !stop_write
		|=> dir == pwm_pkg::DIR_DOWN && cnt == $past(cnt) - 10'h001)
		else $error("no turn at period");

	a_underflow_out: assert property (
		tick && dir == pwm_pkg::DIR_DOWN && cnt == 10'h001 && !stop_write
		|=> cnt == pwm_pkg::CNT_ZERO && UNDERFLOW)
		else $error("underflow pulse missing");

	a_clear_counter: assert property (
		stop_write |=> (cmp[0] == 10'h000 && PWM_OE_N == 6'h3F)
		##1 cnt == pwm_pkg::CNT_ZERO)
		else $error("run clear did not clear");

	a_cmp_locked: assert property (
		WR && ADDR == pwm_pkg::OFS_CMP && run && !valley && !stop_write
		|=> cmp[0] == $past(cmp[0]))
		else $error("compare written while running");

	a_dt_locked: assert property (
		WR && ADDR == pwm_pkg::OFS_DT && run |=> dt == $past(dt))
		else $error("dead time written while running");

	a_valley_load: assert property (
		valley && !stop_write |=> cmp[1] == $past(shd[1]) ##0 VALLEY_IRQ)
		else $error("shadow not transferred");

	a_shadow_write: assert property (
		WR && ADDR == pwm_pkg::OFS_SHD |=> shd[0] == $past(WDATA[9:0]))
		else $error("shadow write lost");

	a_aux_irq: assert property (
		match[4] |=> AUX_IRQ_A)
		else $error("aux interrupt missing");

	a_no_overlap: assert property (
		!(act[0] && act[1]) && !(act[2] && act[3]) && !(act[4] && act[5]))
		else $error("phase pair overlap");

	a_valley_every: assert property (
		uf && div == 3'h0 && !stop_write && ctl == $past(ctl) |=> VALLEY_IRQ)
		else $error("valley interrupt skipped");

	c_valley: cover property (VALLEY_IRQ);
	c_turn: cover property (dir == pwm_pkg::DIR_DOWN ##1 dir == pwm_pkg::DIR_UP);
	c_stop: cover property (out_ok ##1 EXT_STOP ##1 !out_ok);
	c_aux: cover property (AUX_IRQ_B);

endmodule
`default_nettype wire

// [testbench/gate_driver_model.sv]
// Gate driver stand-in: drives the stop input and flags shorted legs.
// Assumes pin levels settle before each rising edge of the system clock.
`timescale 1ns/1ps
`default_nettype none

module gate_driver_model
(
	input wire logic clk,
	input wire logic [5:0] pwm,
	input wire logic [5:0] oe_n,
	input wire logic alv,
	input wire logic stop_req,
	output logic ext_stop,
	output int overlaps,
	output int edges
);
	// Each output has one driver; the counters start from a known zero.
	logic stop_q = 1'b0;
	logic [5:0] last = 6'h00;
	int n_over = 0;
	int n_edge = 0;

	assign ext_stop = stop_q;
	assign overlaps = n_over;
	assign edges = n_edge;

	// ==========================================================
	// Leg watch
	// A shorted leg destroys a real bridge, so every cycle with the leg enabled is judged.
	always @(posedge clk)
	begin
		stop_q <= stop_req;
		last <= pwm;
		if (oe_n == 6'h00 && pwm != last)
			n_edge <= n_edge + 1;
		for (int g = 0; g < 3; g++)
			if (!oe_n[2*g] && pwm[2*g] == alv && pwm[2*g+1] == alv)
				n_over <= n_over + 1;
	end
endmodule
`default_nettype wire

// [testbench/tb_inverter_pwm_timer_core.sv]
// Self-checking bench for the inverter PWM timer core.
// Assumes the core's register map and a gate driver model beside it.
`timescale 1ns/1ps
`default_nettype none

module tb_inverter_pwm_timer_core;
	logic mclk;
	logic rst = 1'b1;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic ext_stop;
	logic stop_req = 1'b0;
	logic alv = 1'b0;
	logic [5:0] pwm_out;
	logic [5:0] pwm_oe_n;
	logic underflow;
	logic valley_irq;
	logic aux_irq_a;
	logic aux_irq_b;
	int overlaps;
	int edges;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int i;
	int g;
	int sel;
	int span;
	int na;
	int nb;
	int nu;
	logic [9:0] per;
	logic [9:0] shd [3];

	inverter_pwm_timer_core #(.NUM_PH(3)) i_inverter_pwm_timer_core
	(
		.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .EXT_STOP(ext_stop), .PWM_OUT(pwm_out),
		.PWM_OE_N(pwm_oe_n), .UNDERFLOW(underflow),
		.VALLEY_IRQ(valley_irq), .AUX_IRQ_A(aux_irq_a),
		.AUX_IRQ_B(aux_irq_b)
	);

	gate_driver_model i_gate_driver_model
	(
		.clk(mclk), .pwm(pwm_out), .oe_n(pwm_oe_n), .alv(alv),
		.stop_req(stop_req), .ext_stop(ext_stop), .overlaps(overlaps),
		.edges(edges)
	);

	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// ==========================================================
	// Tasks
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// A hang anywhere ends the run through the same report.
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			fail_count++;
			final_report();
		end
	end

	task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic check_num(input int got, input int exp);
		samples_checked++;
		if (got != exp)
		begin
			fail_count++;
			$display("mismatch at %0t: count %0d, expected %0d", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		check_reg(rdata, exp);
	endtask

	// Counts cycles and aux pulses from one valley pulse to the next.
	task automatic measure(output int n, output int ca, output int cb,
		output int cu);
		int k;
		k = 0;
		n = 0;
		ca = 0;
		cb = 0;
		cu = 0;
		while (valley_irq !== 1'b1 && k < 5000)
		begin
			@(posedge mclk);
			#1;
			k++;
		end
		do
		begin
			@(posedge mclk);
			#1;
			n++;
			ca += int'(aux_irq_a === 1'b1);
			cb += int'(aux_irq_b === 1'b1);
			cu += int'(underflow === 1'b1);
		end while (valley_irq !== 1'b1 && n < 5000);
	endtask

	function automatic int exp_span(int p, int s, int div);
		return 2 * p * (1 << s) * (div + 1);
	endfunction

	function automatic logic [15:0] exp_reset(int a);
		if (a == 3 || a == 9 || a == 15 || a == 18)
			return 16'h00FF;
		return 16'h0000;
	endfunction

	// ==========================================================
	// Main sequence
	initial
	begin
		void'($urandom(32'hC97C));
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		#1;
		check_reg({10'h000, pwm_oe_n}, 16'h003F);
		for (i = 0; i < 32; i++)
			rd_chk(5'(i), exp_reset(i));
		reg_wr(5'h1F, 16'hFFFF);
		rd_chk(5'h1F, 16'h0000);
		for (i = 0; i < 8; i++)
		begin
			reg_wr(5'h13, 16'h0000);
			sel = i % 6;
			per = 10'($urandom_range(4, 2));
			alv <= i[0];
			reg_wr(5'h03, {6'h00, per});
			reg_wr(5'h09, {6'h00, per});
			reg_wr(5'h0A, 16'h0001);
			reg_wr(5'h0B, {6'h00, per});
			for (g = 0; g < 3; g++)
			begin
				shd[g] = 10'($urandom_range(per));
				reg_wr(5'(6 + g), {6'h00, shd[g]});
			end
			reg_wr(5'h12, 16'h0000);
			rd_chk(5'h03, {6'h00, per});
			reg_wr(5'h14, {12'h000, alv, 3'h0});
			reg_wr(5'h13, 16'(32'h80 + sel * 8 + i));
			measure(span, na, nb, nu);
			check_num(nu, i + 1);
			check_num(span, exp_span(per, sel, i));
			check_num(na, 2 * (i + 1));
			check_num(nb, i + 1);
			check_reg({10'h000, pwm_oe_n}, 16'h0000);
			reg_wr(5'h12, 16'h0055);
			rd_chk(5'h12, 16'h0000);
			reg_wr(5'h00, 16'h03FF);
			rd_chk(5'h00, {6'h00, shd[0]});
			rd_chk(5'h07, {6'h00, shd[1]});
		end
		stop_req <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		check_reg({10'h000, pwm_oe_n}, 16'h003F);
		stop_req <= 1'b0;
		reg_wr(5'h13, 16'h0000);
		for (g = 0; g < 6; g++)
			if (g != 3)
				rd_chk(5'(g), 16'h0000);
		rd_chk(5'h03, {6'h00, per});
		reg_wr(5'h06, 16'h03A5);
		reg_wr(5'h0C, 16'h005A);
		rd_chk(5'h06, 16'h035A);
		rd_chk(5'h0C, 16'h005A);
		check_num(overlaps, 0);
		check_num(int'(edges > 0), 1);
		final_report();
	end
endmodule
`default_nettype wire
